// [ptdc_pkg.sv]
// Constants for the periodic tick down counter
// Operation
// [RL1] Calibration register mirrors system configuration value
// [RL2] Calibration fields: count, inexact, no-reference
// [RL3] 24-bit down counter, interrupt on zero
// [RL4] Tick from CPU clock or half rate
// [RL5] Clock select one means full rate
// [RL6] Software programs reload for desired interval
// [RL7] Calibration count offered as default reload
// [RL8] Current value write makes counting start fresh
// [RL9] Writing seven enables count, interrupt, full clock
// [RL10] Period equals reload plus one ticks
// [RL11] Software aims for a ten millisecond tick
// [RL12] Counter reloads from reload field at zero
// [RL13] Wrapped flag set on zero, read clears
// [RL14] Bits: enable, interrupt enable, clock select
// [RL15] Current value reads live; write clears
// [RL16] Disabled counter holds and raises nothing
`default_nettype none
package ptdc_pkg;
    // Register byte addresses
    localparam logic [31:0] CSR_ADDR   = 32'he000e010;
    localparam logic [31:0] RVR_ADDR   = 32'he000e014;
    localparam logic [31:0] CVR_ADDR   = 32'he000e018;
    localparam logic [31:0] CALIB_ADDR = 32'he000e01c;
    // Counter width
    localparam int CNT_W = 24;
    // Control and status bit positions
    localparam int CSR_EN_BIT   = 0;
    localparam int CSR_IRQ_BIT  = 1;
    localparam int CSR_CLK_BIT  = 2;
    localparam int CSR_WRAP_BIT = 16;
    // Calibration field positions
    localparam int CAL_CNT_MSB  = 23;
    localparam int CAL_CALIBRATION_INEXACT_FLAG_BIT = 30;
    localparam int CAL_NREF_BIT = 31;
    // Calibration mask keeps reserved bits 29:24 at zero
    localparam logic [31:0] CAL_MASK  = 32'hc0ffffff;
    // Reset values
    localparam logic [31:0] CAL_RST   = 32'h00000004;
    localparam logic [23:0] RVR_RST   = 24'h000000;
    localparam logic [23:0] CVR_RST   = 24'h000000;
    // Value that enables everything at full rate
    localparam logic [31:0] CSR_ALL_ON = 32'h00000007;
    // Count values with special meaning
    localparam logic [23:0] CNT_ZERO  = 24'h000000;
    localparam logic [23:0] CNT_ONE   = 24'h000001;
endpackage
`default_nettype wire

// [ptdc_timer.sv]
// Periodic tick down counter with its memory-mapped registers
`timescale 1ns/100ps
`default_nettype none
module ptdc_timer #(
    // Counter width
    parameter int W = ptdc_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // Register access port
    input  wire logic [31:0] reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Calibration value from the system configuration block
    input  wire logic [31:0] calib_in,
    // Tick interrupt request
    output logic             tick_irq_out
);
    // Control bits
    logic         en_ff,      nxt_en;       // Counter enable
    logic         irq_en_ff,  nxt_irq_en;   // Interrupt enable
    logic         clk_sel_ff, nxt_clk_sel;  // One selects full rate
    // Status and datapath
    logic         wrap_ff,    nxt_wrap;     // Reached zero since read
    logic [W-1:0] reload_ff,  nxt_reload;   // Reload value
    logic [W-1:0] cnt_ff,     nxt_cnt;      // Live count
    logic         div_ff,     nxt_div;      // Half-rate phase
    logic [31:0]  cal_ff,     nxt_cal;      // Mirrored calibration
    logic [31:0]  rdata_ff,   nxt_rdata;    // Read data
    logic         irq_ff,     nxt_irq;      // Interrupt pulse

    // Decoded accesses
    logic wr_csr, wr_rvr, wr_cvr, rd_csr;
    logic tick;     // Counting edge this cycle
    logic hit_zero; // Count passes from one to zero

    // Assertions sample on the rising edge and rest during reset
    default clocking ast_cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    // Address decode of the register port
    always_comb begin
        wr_csr = reg_wr_in && (reg_addr_in == ptdc_pkg::CSR_ADDR);
        wr_rvr = reg_wr_in && (reg_addr_in == ptdc_pkg::RVR_ADDR);
        wr_cvr = reg_wr_in && (reg_addr_in == ptdc_pkg::CVR_ADDR);
        rd_csr = reg_rd_in && (reg_addr_in == ptdc_pkg::CSR_ADDR);
    end

    // Tick source: every cycle, or every second cycle
    // A phase toggle is used so the whole block stays on one clock
    always_comb begin
        nxt_div = ~div_ff; // [RL4]
        tick    = clk_sel_ff ? 1'b1 : div_ff; // [RL4] [RL5]
        hit_zero = en_ff && tick && (cnt_ff == ptdc_pkg::CNT_ONE); // [RL3]
    end

    // Next state of control, counter and flags
    always_comb begin
        nxt_en      = en_ff;
        nxt_irq_en  = irq_en_ff;
        nxt_clk_sel = clk_sel_ff;
        nxt_reload  = reload_ff;
        nxt_cnt     = cnt_ff;
        nxt_wrap    = wrap_ff;
        nxt_irq     = 1'b0;
        // Calibration tracks the configuration block every cycle
        nxt_cal     = calib_in & ptdc_pkg::CAL_MASK; // [RL1] [RL2] [RL7]
        // Control write
        if (wr_csr) begin
            nxt_en      = reg_wdata_in[ptdc_pkg::CSR_EN_BIT];  // [RL14] [RL9]
            nxt_irq_en  = reg_wdata_in[ptdc_pkg::CSR_IRQ_BIT]; // [RL14] [RL9]
            nxt_clk_sel = reg_wdata_in[ptdc_pkg::CSR_CLK_BIT]; // [RL14] [RL9]
        end
        // Reload write; upper bits are dropped
        if (wr_rvr) begin
            nxt_reload = reg_wdata_in[W-1:0]; // [RL6]
        end
        // Reading status clears the flag
        if (rd_csr) begin
            nxt_wrap = 1'b0; // [RL13]
        end
        // Counting; disabled counter holds its value
        if (en_ff && tick) begin // [RL16]
            if (cnt_ff == ptdc_pkg::CNT_ZERO) begin
                // Zero reloads, so a period is reload plus one ticks
                nxt_cnt = reload_ff; // [RL12] [RL10]
            end else begin
                nxt_cnt = cnt_ff - ptdc_pkg::CNT_ONE; // [RL3]
            end
        end
        // Arrival at zero; set wins over a read clear
        if (hit_zero) begin
            nxt_wrap = 1'b1;       // [RL13]
            nxt_irq  = irq_en_ff;  // [RL3] [RL14]
        end
        // Any write to the current value clears count and flag, so the
        // next enabled tick loads the reload value
        if (wr_cvr) begin
            nxt_cnt  = ptdc_pkg::CVR_RST; // [RL15] [RL8]
            nxt_wrap = 1'b0;              // [RL15]
        end
    end

    // Read multiplexer; unmapped addresses and reserved bits read zero
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                ptdc_pkg::CSR_ADDR: begin
                    nxt_rdata[ptdc_pkg::CSR_EN_BIT]   = en_ff;
                    nxt_rdata[ptdc_pkg::CSR_IRQ_BIT]  = irq_en_ff;
                    nxt_rdata[ptdc_pkg::CSR_CLK_BIT]  = clk_sel_ff;
                    nxt_rdata[ptdc_pkg::CSR_WRAP_BIT] = wrap_ff; // [RL13]
                end
                ptdc_pkg::RVR_ADDR: begin
                    nxt_rdata[W-1:0] = reload_ff;
                end
                ptdc_pkg::CVR_ADDR: begin
                    nxt_rdata[W-1:0] = cnt_ff; // [RL15]
                end
                ptdc_pkg::CALIB_ADDR: begin
                    nxt_rdata = cal_ff; // [RL1] [RL2]
                end
                default: begin
                    nxt_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            en_ff      <= 1'b0;
            irq_en_ff  <= 1'b0;
            clk_sel_ff <= 1'b0;
            wrap_ff    <= 1'b0;
            reload_ff  <= ptdc_pkg::RVR_RST;
            cnt_ff     <= ptdc_pkg::CVR_RST;
            div_ff     <= 1'b0;
            cal_ff     <= ptdc_pkg::CAL_RST; // [RL2]
            rdata_ff   <= 32'h00000000;
            irq_ff     <= 1'b0;
        end else begin
            en_ff      <= nxt_en;
            irq_en_ff  <= nxt_irq_en;
            clk_sel_ff <= nxt_clk_sel;
            wrap_ff    <= nxt_wrap;
            reload_ff  <= nxt_reload;
            cnt_ff     <= nxt_cnt;
            div_ff     <= nxt_div;
            cal_ff     <= nxt_cal;
            rdata_ff   <= nxt_rdata;
            irq_ff     <= nxt_irq;
        end
    end

    // Outputs come straight from flip-flops
    assign reg_rdata_out = rdata_ff;
    assign tick_irq_out  = irq_ff;

    // Checks of the counting behaviour
    AST_IRQ_AT_ZERO: assert property ( // [RL3]
        hit_zero && irq_en_ff |=> tick_irq_out)
        else $error("no interrupt when count reached zero");

    AST_RELOAD: assert property ( // [RL12]
        en_ff && tick && cnt_ff == ptdc_pkg::CNT_ZERO && !wr_cvr
        |=> cnt_ff == $past(reload_ff))
        else $error("counter did not reload at zero");

    AST_FULL_RATE: assert property ( // [RL5]
        en_ff && clk_sel_ff && cnt_ff > ptdc_pkg::CNT_ONE && !reg_wr_in
        |=> cnt_ff == $past(cnt_ff) - ptdc_pkg::CNT_ONE)
        else $error("full rate counter did not step each cycle");

    // A count above one cannot reach the reload point in two cycles
    AST_HALF_RATE: assert property ( // [RL4]
        (en_ff && !clk_sel_ff && cnt_ff > ptdc_pkg::CNT_ONE && !reg_wr_in)
        ##1 !reg_wr_in
        |=> cnt_ff == $past(cnt_ff, 2) - ptdc_pkg::CNT_ONE)
        else $error("half rate counter did not step once in two cycles");

    AST_HOLD: assert property ( // [RL16]
        !en_ff && !reg_wr_in |=> $stable(cnt_ff) && !tick_irq_out)
        else $error("disabled counter changed or raised interrupt");

    // Checks of the register side effects
    AST_CVR_CLEAR: assert property ( // [RL15]
        wr_cvr |=> cnt_ff == ptdc_pkg::CNT_ZERO && !wrap_ff)
        else $error("current value write did not clear count and flag");

    AST_READ_CLEAR: assert property ( // [RL13]
        rd_csr && !hit_zero && !reg_wr_in
        |=> !wrap_ff
            && reg_rdata_out[ptdc_pkg::CSR_WRAP_BIT] == $past(wrap_ff))
        else $error("status read did not return and clear the flag");

    AST_WRAP_SET: assert property ( // [RL13]
        hit_zero && !wr_cvr |=> wrap_ff)
        else $error("flag not set on reaching zero");

    AST_ALL_ON: assert property ( // [RL9]
        wr_csr && reg_wdata_in == ptdc_pkg::CSR_ALL_ON
        |=> en_ff && irq_en_ff && clk_sel_ff)
        else $error("writing seven did not enable all");

    // Mirror lags its source by one cycle, read data by one more
    AST_CALIB: assert property ( // [RL1]
        reg_rd_in && reg_addr_in == ptdc_pkg::CALIB_ADDR
        |=> reg_rdata_out == ($past(calib_in, 2) & ptdc_pkg::CAL_MASK))
        else $error("calibration read differs from source");

    AST_NO_IRQ_OFF: assert property ( // [RL14]
        !irq_en_ff |=> !tick_irq_out)
        else $error("interrupt raised while disabled");

    // Main scenarios
    COV_IRQ: cover property (tick_irq_out);
    COV_HALF_WRAP: cover property (hit_zero && !clk_sel_ff);
    COV_READ_FLAG: cover property (rd_csr && wrap_ff);
    // Flag set and read clear meet in one cycle
    COV_SET_WINS: cover property (hit_zero && rd_csr);
endmodule
`default_nettype wire

// [ptdc_timer_tb_top.sv]
// Self-checking testbench for the periodic tick down counter
`timescale 1ns/100ps
`default_nettype none
module ptdc_timer_tb_top;
    // Stimulus driven at the falling edge
    logic        clock_in     = 1'b0;
    logic        rst_in       = 1'b1;
    logic [31:0] reg_addr_in  = 32'h00000000;
    logic        reg_wr_in    = 1'b0;
    logic [31:0] reg_wdata_in = 32'h00000000;
    logic        reg_rd_in    = 1'b0;
    logic [31:0] calib_in     = 32'h00000000;
    // Observed outputs
    logic [31:0] reg_rdata_out;
    logic        tick_irq_out;
    // Scoreboard and scratch
    int          num_errors      = 0;
    int          samples_checked = 0;
    int          per;
    logic [31:0] v;
    logic [31:0] v2;
    logic [23:0] rel;
    logic [31:0] csr;

    // 40 MHz clock
    always #12.5 clock_in = ~clock_in;

    ptdc_timer dut_u (
        .clock_in      (clock_in),
        .rst_in        (rst_in),
        .reg_addr_in   (reg_addr_in),
        .reg_wr_in     (reg_wr_in),
        .reg_wdata_in  (reg_wdata_in),
        .reg_rd_in     (reg_rd_in),
        .reg_rdata_out (reg_rdata_out),
        .calib_in      (calib_in),
        .tick_irq_out  (tick_irq_out)
    );

    // Case equality so an unknown never passes
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge clock_in);
        reg_addr_in  = a;
        reg_wdata_in = d;
        reg_wr_in    = 1'b1;
        @(negedge clock_in);
        reg_wr_in = 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(negedge clock_in);
        reg_addr_in = a;
        reg_rd_in   = 1'b1;
        @(negedge clock_in);
        reg_rd_in = 1'b0;
        d = reg_rdata_out;
    endtask
    // Cycles between two interrupt pulses, bounded
    task automatic irq_gap(output int n);
        int k;
        k = 0;
        while (tick_irq_out !== 1'b1 && k < 200) begin
            @(negedge clock_in);
            k++;
        end
        @(negedge clock_in);
        n = 1;
        while (tick_irq_out !== 1'b1 && n < 200) begin
            @(negedge clock_in);
            n++;
        end
    endtask
    // Pulses seen over a window
    task automatic quiet(input int w, output int n);
        n = 0;
        repeat (w) begin
            @(negedge clock_in);
            if (tick_irq_out === 1'b1) n++;
        end
    endtask
    // Control, reload and current value registers read back their reset values
    task automatic reset_checks;
        logic [31:0] r;
        rd(ptdc_pkg::CSR_ADDR, r);
        chk(r, 32'h00000000);
        rd(ptdc_pkg::RVR_ADDR, r);
        chk(r, 32'h00000000);
        rd(ptdc_pkg::CVR_ADDR, r);
        chk(r, 32'h00000000);
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles needed
    initial begin
        #500000;
        num_errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h7dceaf1c));
        calib_in = $urandom();
        repeat (2) @(negedge clock_in);
        rst_in = 1'b0;
        reset_checks();
        // Calibration mirrors its input; writes are ignored
        calib_in = $urandom();
        wr(ptdc_pkg::CALIB_ADDR, ~calib_in);
        rd(ptdc_pkg::CALIB_ADDR, v);
        chk(v, calib_in & 32'hc0ffffff);
        rd(32'he000e020, v);
        chk(v, 32'h00000000);
        // Reload 1 is the tightest corner, then random reloads
        for (int i = 0; i < 4; i++) begin
            rel = (i == 0) ? 24'h000001 : 24'($urandom_range(2, 9));
            csr = (i % 2 == 0) ? 32'h00000007 : 32'h00000003;
            wr(ptdc_pkg::RVR_ADDR, {8'($urandom()), rel});
            rd(ptdc_pkg::RVR_ADDR, v);
            chk(v, {8'h00, rel});
            wr(ptdc_pkg::CVR_ADDR, $urandom());
            rd(ptdc_pkg::CVR_ADDR, v);
            chk(v, 32'h00000000);
            wr(ptdc_pkg::CSR_ADDR, csr);
            irq_gap(per);
            chk(per, (rel + 1) * (csr[2] ? 1 : 2));
            rd(ptdc_pkg::CVR_ADDR, v);
            chk({31'h0, v <= {8'h00, rel}}, 32'h00000001);
            rd(ptdc_pkg::CSR_ADDR, v);
            chk(v, csr | 32'h00010000);
            wr(ptdc_pkg::CSR_ADDR, 32'h00000000);
            rd(ptdc_pkg::CSR_ADDR, v);
            rd(ptdc_pkg::CSR_ADDR, v);
            chk(v, 32'h00000000);
            rd(ptdc_pkg::CVR_ADDR, v);
            quiet(20, per);
            chk(per, 0);
            rd(ptdc_pkg::CVR_ADDR, v2);
            chk(v2, v);
        end
        // Interrupt masked: flag still sets, no pulse
        wr(ptdc_pkg::CVR_ADDR, 32'h00000000);
        rd(ptdc_pkg::CSR_ADDR, v);
        wr(ptdc_pkg::CSR_ADDR, 32'h00000005);
        quiet(30, per);
        chk(per, 0);
        rd(ptdc_pkg::CSR_ADDR, v);
        chk(v, 32'h00010005);
        // Writing the current value clears the flag
        wr(ptdc_pkg::CSR_ADDR, 32'h00000000);
        wr(ptdc_pkg::CVR_ADDR, $urandom());
        rd(ptdc_pkg::CSR_ADDR, v);
        chk(v, 32'h00000000);
        // Software adopts the calibration count as its reload
        calib_in = {8'($urandom()), 24'($urandom_range(2, 9))};
        rd(ptdc_pkg::CALIB_ADDR, v);
        wr(ptdc_pkg::RVR_ADDR, {8'h00, v[23:0]});
        wr(ptdc_pkg::CVR_ADDR, 32'h00000000);
        wr(ptdc_pkg::CSR_ADDR, 32'h00000007);
        irq_gap(per);
        chk(per, calib_in[23:0] + 1);
        // Reset in mid-run, while counting with interrupts on
        @(negedge clock_in);
        rst_in = 1'b1;
        repeat (2) @(negedge clock_in);
        rst_in = 1'b0;
        reset_checks();
        quiet(10, per);
        chk(per, 0);
        end_of_test();
    end
endmodule
`default_nettype wire
